// ---- rtl/vfbp_map.vh ----
// Purpose: register map, field positions and frame sizes of the voice frame packer
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef VFBP_MAP_VH
`define VFBP_MAP_VH

// register byte offsets
`define VFBP_CTRL_ADDR    12'h000
`define VFBP_FIELD_ADDR   12'h004
`define VFBP_STAT_ADDR    12'h008
`define VFBP_COUNT_ADDR   12'h00C

// control register fields
`define VFBP_C_RATE       0
`define VFBP_C_CORE       4
`define VFBP_C_EXT        6
`define VFBP_C_VRATE      7
`define VFBP_C_START      8

// header field register fields
`define VFBP_F_BAND       0
`define VFBP_F_TYPE       4
`define VFBP_F_JOINT      8
`define VFBP_F_TCXCT      16
`define VFBP_F_FD         18
`define VFBP_F_PREV       19
`define VFBP_F_ISR        20
`define VFBP_F_RSV        21
`define VFBP_F_LOW        24
`define VFBP_F_VHI        26
`define VFBP_FIELD_MASK   32'h07FF_FFFF

// rate codes
`define VFBP_R28          3'h0
`define VFBP_R72          3'h1
`define VFBP_R80          3'h2
`define VFBP_R96          3'h3
`define VFBP_R132         3'h4
`define VFBP_R164         3'h5
`define VFBP_R244         3'h6

// core codes and bandwidth codes
`define VFBP_PRED         2'h0
`define VFBP_HQ           2'h1
`define VFBP_EXC          2'h2
`define VFBP_BAND_WIDE    2'h1

// frame lengths in bits
`define VFBP_LEN28        9'h038
`define VFBP_LEN72        9'h090
`define VFBP_LEN80        9'h0A0
`define VFBP_LEN96        9'h0C0
`define VFBP_LEN132       9'h108
`define VFBP_LEN164       9'h148
`define VFBP_LEN244       9'h1E8
`define VFBP_PAD_BITS     9'h003
`define VFBP_VRATE_TARGET 12'h076

`endif

// ---- rtl/vfbp_packer.v ----
// Purpose: packs the header of each coded voice frame and streams the frame msb first
// Assumes: payload bits come from core logic on ref_clk; apb slave with no wait state
// Notes:   one frame per start command; serial output cannot be stalled
//
// What this block does
// - every field goes out msb first
// - variable rate picks frames averaging 5.9 kbps
// - 2.8 kbps type: active bit, two type bits
// - frame lengths 56, 144, 160, 192 bits
// - 7.2/8.0 joint index also marks core
// - no extension field at 7.2/8.0
// - 9.6 core choice inside coder type
// - 13.2 frames 264 bits, 5-bit joint index
// - 13.2 joint index marks predictive or transform
// - 13.2 transform adds high-quality/excited bit
// - 13.2 excited core adds 2 type bits
// - 13.2 wide-band predictive adds extension flag
// - 16.4 frames 328 bits with padding
// - 24.4 frames 488 bits with padding
// - 24.4 core flag predictive or transform
// - next bit picks quality or excited core
// - excited core then carries 2 type bits
// - quality core flags previous predictive frame
// - second switch bit gives internal rate
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "vfbp_map.vh"

module vfbp_packer (
   // clock and reset
   input  wire        ref_clk,
   input  wire        reset_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // payload bits from the core logic
   input  wire        core_bit,
   input  wire        core_valid,
   output reg         core_ready,
   // serial frame bitstream
   output reg         ser_data,
   output reg         ser_valid,
   output reg         ser_first,
   output reg         ser_last,
   output reg         frame_busy
);

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_HDR  = 4'h2;
   localparam [3:0] ST_PAY  = 4'h4;
   localparam [3:0] ST_PAD  = 4'h8;

   reg  [8:0]  ctrl_r;
   reg  [26:0] field_r;
   reg  [3:0]  state_r;
   reg  [7:0]  hdr_r;
   reg  [3:0]  hlen_r;
   reg  [8:0]  flen_r;
   reg  [8:0]  plen_r;
   reg         pad_r;
   reg  [8:0]  cnt_r;
   reg  [8:0]  tot_r;
   reg  [11:0] acc_r;
   reg  [2:0]  lrate_r;
   reg  [15:0] frames_r;

   // builds the header bits, right aligned, with their count in the top nibble
   function [11:0] hdr_build;
      input [2:0]  rate;
      input [1:0]  core;
      input        ext;
      input [26:0] f;
      reg   [7:0]  v;
      reg   [3:0]  n;
      begin
         v = 8'h00;
         n = 4'h0;
         case (rate)
            `VFBP_R28: begin
               v = {5'h00, 1'b1, f[`VFBP_F_LOW+1:`VFBP_F_LOW]};
               n = 4'h3;
            end
            `VFBP_R72, `VFBP_R80: begin
               // joint index only, no extension flag follows
               v = {4'h0, core != `VFBP_PRED, f[`VFBP_F_JOINT+2:`VFBP_F_JOINT]};
               n = 4'h4;
            end
            `VFBP_R96: begin
               v = {3'h0, f[`VFBP_F_BAND+1:`VFBP_F_BAND], core == `VFBP_EXC,
                    f[`VFBP_F_TYPE+1:`VFBP_F_TYPE]};
               n = 4'h5;
            end
            `VFBP_R132: begin
               v = {3'h0, core != `VFBP_PRED, f[`VFBP_F_JOINT+3:`VFBP_F_JOINT]};
               n = 4'h5;
               if (core != `VFBP_PRED) begin
                  v = {v[6:0], core == `VFBP_EXC};
                  n = n + 4'h1;
               end
               if (core == `VFBP_EXC) begin
                  v = {v[5:0], f[`VFBP_F_TCXCT+1:`VFBP_F_TCXCT]};
                  n = n + 4'h2;
               end
               if (core == `VFBP_PRED && ext &&
                   f[`VFBP_F_BAND+1:`VFBP_F_BAND] == `VFBP_BAND_WIDE) begin
                  v = {v[6:0], f[`VFBP_F_FD]};
                  n = n + 4'h1;
               end
            end
            `VFBP_R164: begin
               v = {6'h00, f[`VFBP_F_BAND+1:`VFBP_F_BAND]};
               n = 4'h2;
               if (core == `VFBP_EXC) begin
                  v = {v[6:0], f[`VFBP_F_RSV]};
                  n = n + 4'h1;
               end
               // coder type width depends on the core
               if (core == `VFBP_PRED) begin
                  v = {v[4:0], f[`VFBP_F_TYPE+2:`VFBP_F_TYPE]};
                  n = n + 4'h3;
               end else if (core == `VFBP_EXC) begin
                  v = {v[3:0], f[`VFBP_F_TYPE+3:`VFBP_F_TYPE]};
                  n = n + 4'h4;
               end else begin
                  v = {v[5:0], f[`VFBP_F_TYPE+1:`VFBP_F_TYPE]};
                  n = n + 4'h2;
               end
            end
            `VFBP_R244: begin
               v = {6'h00, f[`VFBP_F_BAND+1:`VFBP_F_BAND]};
               n = 4'h2;
               if (core == `VFBP_EXC) begin
                  v = {v[6:0], f[`VFBP_F_RSV]};
                  n = n + 4'h1;
               end
               v = {v[6:0], core != `VFBP_PRED};
               n = n + 4'h1;
               if (core != `VFBP_PRED) begin
                  v = {v[6:0], core == `VFBP_EXC};
                  n = n + 4'h1;
               end
               if (core == `VFBP_HQ) begin
                  v = {v[6:0], f[`VFBP_F_PREV]};
                  n = n + 4'h1;
                  if (f[`VFBP_F_PREV]) begin
                     v = {v[6:0], f[`VFBP_F_ISR]};
                     n = n + 4'h1;
                  end
               end else begin
                  v = {v[5:0], f[`VFBP_F_TYPE+1:`VFBP_F_TYPE]};
                  n = n + 4'h2;
               end
            end
            default: begin
               v = 8'h00;
               n = 4'h0;
            end
         endcase
         hdr_build = {n, v};
      end
   endfunction

   // frame length for a rate
   function [8:0] frame_len;
      input [2:0] rate;
      begin
         case (rate)
            `VFBP_R28:  frame_len = `VFBP_LEN28;
            `VFBP_R72:  frame_len = `VFBP_LEN72;
            `VFBP_R80:  frame_len = `VFBP_LEN80;
            `VFBP_R96:  frame_len = `VFBP_LEN96;
            `VFBP_R132: frame_len = `VFBP_LEN132;
            `VFBP_R164: frame_len = `VFBP_LEN164;
            `VFBP_R244: frame_len = `VFBP_LEN244;
            default:    frame_len = `VFBP_LEN28;
         endcase
      end
   endfunction

   // apb strobes
   wire       wr_en  = psel & penable & pwrite & pready;
   wire       setup  = psel & ~penable;
   wire       hit    = (paddr == `VFBP_CTRL_ADDR) | (paddr == `VFBP_FIELD_ADDR) |
                       (paddr == `VFBP_STAT_ADDR) | (paddr == `VFBP_COUNT_ADDR);
   wire       start  = wr_en & (paddr == `VFBP_CTRL_ADDR) & pwdata[`VFBP_C_START] &
                       (state_r == ST_IDLE);
   wire       acc_pos = ~acc_r[11] & (acc_r != 12'h000);

   // frame choice: variable rate overrides the programmed rate and core
   reg  [2:0]  sel_rate;
   reg  [1:0]  sel_core;
   reg  [11:0] hdr_sel;
   reg  [8:0]  flen_sel;
   reg         pad_sel;
   always @* begin
      sel_rate = pwdata[`VFBP_C_RATE+2:`VFBP_C_RATE];
      sel_core = pwdata[`VFBP_C_CORE+1:`VFBP_C_CORE];
      if (pwdata[`VFBP_C_VRATE]) begin
         // low-rate frame while ahead of the average, else a full frame
         sel_core = `VFBP_PRED;
         if (acc_pos)
            sel_rate = `VFBP_R28;
         else if (field_r[`VFBP_F_VHI])
            sel_rate = `VFBP_R80;
         else
            sel_rate = `VFBP_R72;
      end
      hdr_sel  = hdr_build(sel_rate, sel_core, pwdata[`VFBP_C_EXT], field_r);
      flen_sel = frame_len(sel_rate);
      pad_sel  = pwdata[`VFBP_C_EXT] &
                 ((sel_rate == `VFBP_R164) | (sel_rate == `VFBP_R244));
   end

   // bit source for the current section
   reg        emit;
   reg        ebit;
   reg  [3:0] sh;
   always @* begin
      emit = 1'b0;
      ebit = 1'b0;
      sh   = hlen_r - 4'h1 - cnt_r[3:0];
      case (state_r)
         ST_HDR: begin
            emit = 1'b1;
            ebit = hdr_r[sh[2:0]];
         end
         ST_PAY: begin
            emit = core_valid & core_ready;
            ebit = core_bit;
         end
         ST_PAD: emit = 1'b1;
         default: begin
            emit = 1'b0;
            ebit = 1'b0;
         end
      endcase
   end

   // apb registers and answers
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r  <= 9'h000;
         field_r <= 27'h000_0000;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         if (setup) begin
            case (paddr)
               `VFBP_CTRL_ADDR:  prdata <= {23'h00_0000, 1'b0, ctrl_r[7:0]};
               `VFBP_FIELD_ADDR: prdata <= {5'h00, field_r};
               `VFBP_STAT_ADDR:  prdata <= {12'h000, acc_r, 3'h0, lrate_r, 1'b0,
                                           state_r[3:1] != 3'h0};
               `VFBP_COUNT_ADDR: prdata <= {16'h0000, frames_r};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
         if (wr_en && paddr == `VFBP_CTRL_ADDR)
            ctrl_r <= {1'b0, pwdata[7:0]};
         if (wr_en && paddr == `VFBP_FIELD_ADDR)
            field_r <= pwdata[26:0];
      end
   end

   // frame sequencer: header, then core and extension bits, then padding
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= ST_IDLE;
         hdr_r      <= 8'h00;
         hlen_r     <= 4'h0;
         flen_r     <= 9'h000;
         plen_r     <= 9'h000;
         pad_r      <= 1'b0;
         cnt_r      <= 9'h000;
         tot_r      <= 9'h000;
         acc_r      <= 12'h000;
         lrate_r    <= 3'h0;
         frames_r   <= 16'h0000;
         core_ready <= 1'b0;
         ser_data   <= 1'b0;
         ser_valid  <= 1'b0;
         ser_first  <= 1'b0;
         ser_last   <= 1'b0;
         frame_busy <= 1'b0;
      end else begin
         ser_valid <= emit;
         ser_data  <= ebit;
         ser_first <= emit & (tot_r == 9'h000);
         ser_last  <= emit & (tot_r == flen_r - 9'h001);
         if (emit)
            tot_r <= tot_r + 9'h001;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r    <= ST_HDR;
                  hdr_r      <= hdr_sel[7:0];
                  hlen_r     <= hdr_sel[11:8];
                  flen_r     <= flen_sel;
                  pad_r      <= pad_sel;
                  // payload fills the frame exactly after header and padding
                  plen_r     <= flen_sel - {5'h00, hdr_sel[11:8]} -
                                (pad_sel ? `VFBP_PAD_BITS : 9'h000);
                  lrate_r    <= sel_rate;
                  cnt_r      <= 9'h000;
                  tot_r      <= 9'h000;
                  frame_busy <= 1'b1;
                  if (pwdata[`VFBP_C_VRATE])
                     acc_r <= acc_r + {3'h0, flen_sel} - `VFBP_VRATE_TARGET;
               end
            end
            ST_HDR: begin
               if (cnt_r == {5'h00, hlen_r} - 9'h001) begin
                  state_r    <= ST_PAY;
                  cnt_r      <= 9'h000;
                  core_ready <= 1'b1;
               end else
                  cnt_r <= cnt_r + 9'h001;
            end
            ST_PAY: begin
               if (emit) begin
                  if (cnt_r == plen_r - 9'h001) begin
                     core_ready <= 1'b0;
                     cnt_r      <= 9'h000;
                     state_r    <= pad_r ? ST_PAD : ST_IDLE;
                     if (!pad_r) begin
                        frame_busy <= 1'b0;
                        frames_r   <= frames_r + 16'h0001;
                     end
                  end else
                     cnt_r <= cnt_r + 9'h001;
               end
            end
            ST_PAD: begin
               if (cnt_r == `VFBP_PAD_BITS - 9'h001) begin
                  state_r    <= ST_IDLE;
                  cnt_r      <= 9'h000;
                  frame_busy <= 1'b0;
                  frames_r   <= frames_r + 16'h0001;
               end else
                  cnt_r <= cnt_r + 9'h001;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

endmodule

// ---- verification/vfbp_props.sv ----
// Purpose: port-level protocol checks of the frame packer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every vfbp_packer instance
module vfbp_props (
   // clock and reset
   input wire        ref_clk,
   input wire        reset_n,
   // apb slave side
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        pready,
   input wire        pslverr,
   // payload and serial stream
   input wire        core_bit,
   input wire        core_valid,
   input wire        core_ready,
   input wire        ser_data,
   input wire        ser_valid,
   input wire        ser_first,
   input wire        ser_last,
   input wire        frame_busy,
   // start bit of the write data
   input wire        pwdata_start
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [8:0] n_r;
   // bits seen so far in the current frame
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         n_r <= 9'h000;
      else if (ser_valid)
         n_r <= ser_first ? 9'h001 : n_r + 9'h001;
   AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   AST_SLVERR: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
      12'h008, 12'h00C}))
      else $error("error response does not match address");
   AST_START: assert property (psel && penable && pready && pwrite && paddr == 12'h000
      && pwdata_start && !frame_busy |=> frame_busy ##[1:3] (ser_first && ser_valid))
      else $error("start did not begin a frame");
   AST_FIRST: assert property (ser_first |-> ser_valid ##1 !ser_first)
      else $error("first marker not a single valid pulse");
   AST_LEN: assert property (ser_valid && ser_last && !ser_first |->
      (n_r + 9'h001) inside {56, 144, 160, 192, 264, 328, 488})
      else $error("frame length not a legal size");
   AST_END: assert property (ser_valid && ser_last |-> ##[0:1] !frame_busy)
      else $error("busy outlives the last bit");
   AST_READY: assert property (core_ready |-> frame_busy)
      else $error("payload accepted while idle");
   AST_PAYLOAD: assert property (core_ready && core_valid |=>
      ser_valid && ser_data == $past(core_bit))
      else $error("payload bit not passed on in place");
endmodule
bind vfbp_packer vfbp_props i_props (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
   .pready, .pslverr, .core_bit, .core_valid, .core_ready, .ser_data, .ser_valid,
   .ser_first, .ser_last, .frame_busy, .pwdata_start(pwdata[8]));

// ---- verification/vfbp_decoder_model.sv ----
// Purpose: decoder-side model consuming the packed frame bitstream
// Assumes: one bit per ser_valid cycle, the stream cannot be stalled
// Notes:   reports length, first sixteen bits and last three bits of a frame
module vfbp_decoder_model (
   // clock and reset
   input  wire         ref_clk,
   input  wire         reset_n,
   // serial frame bitstream
   input  wire         ser_data,
   input  wire         ser_valid,
   input  wire         ser_first,
   input  wire         ser_last,
   // frame report
   output logic        frame_done,
   output logic [8:0]  frame_len,
   output logic [15:0] hdr,
   output logic [2:0]  tail
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] cnt_r;
   // gather bits msb first, header taken from the leading bits
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 9'h000;
         frame_done <= 1'b0;
         frame_len <= 9'h000;
         hdr <= 16'h0000;
         tail <= 3'h0;
      end else begin
         frame_done <= ser_valid && ser_last;
         if (ser_valid) begin
            cnt_r <= ser_first ? 9'h001 : cnt_r + 9'h001;
            tail <= {tail[1:0], ser_data};
            if (ser_first)
               hdr <= {15'h0000, ser_data};
            else if (cnt_r < 9'h010)
               hdr <= {hdr[14:0], ser_data};
            if (ser_last)
               frame_len <= ser_first ? 9'h001 : cnt_r + 9'h001;
         end
      end
   end
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the voice frame packer
// Assumes: rtl header on the include path
// Notes:   frames are judged through the decoder model
`include "vfbp_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int len; int hn; logic [15:0] hb; bit pad;} vfbp_exp_t;
   logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic core_bit = 0, core_valid = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, q;
   wire [31:0] prdata;
   wire pready, pslverr, core_ready, ser_data, ser_valid, ser_first, ser_last, frame_busy;
   wire dec_done;
   wire [8:0] dec_len;
   wire [15:0] dec_hdr;
   wire [2:0] dec_tail;
   int err_total = 0, checked = 0, cyc = 0;
   vfbp_exp_t ex, got, eq[$];

   vfbp_packer i_dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .core_bit, .core_valid, .core_ready, .ser_data,
      .ser_valid, .ser_first, .ser_last, .frame_busy);
   vfbp_decoder_model i_dec (.ref_clk, .reset_n, .ser_data, .ser_valid, .ser_first,
      .ser_last, .frame_done(dec_done), .frame_len(dec_len), .hdr(dec_hdr), .tail(dec_tail));

   // clock
   always #50 ref_clk = ~ref_clk;

   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string n);
      logic e;
      apb(1'b0, a, 32'h0000_0000, e);
      chk(n, q, exp);
   endtask

   // append a field of w bits to the expected header, msb first
   task automatic put(input logic [3:0] v, input int w);
      ex.hb = (ex.hb << w) | (v & ~(16'h000F << w));
      ex.hn += w;
   endtask

   // expected header layout and frame size
   task automatic plan(input logic [2:0] r, input logic [1:0] c, input logic x,
                       input logic [31:0] f);
      ex.hn = 0;
      ex.hb = 16'h0000;
      ex.pad = x && r >= `VFBP_R164;
      case (r)
         `VFBP_R28: begin
            put(4'h1, 1);
            put(f[25:24], 2);
            ex.len = `VFBP_LEN28;
         end
         `VFBP_R72, `VFBP_R80: begin
            put(c != `VFBP_PRED, 1);
            put(f[10:8], 3);
            ex.len = r == `VFBP_R72 ? `VFBP_LEN72 : `VFBP_LEN80;
         end
         `VFBP_R96: begin
            put(f[1:0], 2);
            put(c == `VFBP_EXC, 1);
            put(f[5:4], 2);
            ex.len = `VFBP_LEN96;
         end
         `VFBP_R132: begin
            put(c != `VFBP_PRED, 1);
            put(f[11:8], 4);
            if (c != `VFBP_PRED)
               put(c == `VFBP_EXC, 1);
            if (c == `VFBP_EXC)
               put(f[17:16], 2);
            if (c == `VFBP_PRED && x && f[1:0] == `VFBP_BAND_WIDE)
               put(f[18], 1);
            ex.len = `VFBP_LEN132;
         end
         `VFBP_R164: begin
            put(f[1:0], 2);
            if (c == `VFBP_EXC)
               put(f[21], 1);
            put(f[7:4], c == `VFBP_PRED ? 3 : c == `VFBP_EXC ? 4 : 2);
            ex.len = `VFBP_LEN164;
         end
         default: begin
            put(f[1:0], 2);
            if (c == `VFBP_EXC)
               put(f[21], 1);
            put(c != `VFBP_PRED, 1);
            if (c != `VFBP_PRED)
               put(c == `VFBP_EXC, 1);
            if (c == `VFBP_HQ) begin
               put(f[19], 1);
               if (f[19])
                  put(f[20], 1);
            end else
               put(f[5:4], 2);
            ex.len = `VFBP_LEN244;
         end
      endcase
   endtask

   // one frame; a second start while busy must be ignored
   task automatic frame(input logic [2:0] r, input logic [1:0] c, input logic x,
                        input logic [31:0] f, input logic v);
      logic e;
      apb(1'b1, `VFBP_FIELD_ADDR, f, e);
      plan(r, c, x, f);
      eq.push_back(ex);
      apb(1'b1, `VFBP_CTRL_ADDR, {23'h00_0000, 1'b1, v, x, c, 1'b0, r}, e);
      apb(1'b1, `VFBP_CTRL_ADDR, {23'h00_0000, 1'b1, v, x, c, 1'b0, r}, e);
      while (frame_busy !== 1'b0)
         @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
   endtask

   // payload source with random stalls
   always @(posedge ref_clk) begin
      core_valid <= ($urandom % 4) != 0;
      core_bit <= 1'($urandom);
   end

   // compare each finished frame against the oldest note
   always @(posedge ref_clk) begin
      if (dec_done === 1'b1) begin
         if (eq.size() == 0)
            chk("frame count", 32'h0000_0001, 32'h0000_0000);
         else begin
            got = eq.pop_front();
            chk("frame length", dec_len, got.len);
            chk("header", dec_hdr >> (16 - got.hn), got.hb);
            if (got.pad)
               chk("padding", dec_tail, 32'h0000_0000);
         end
      end
   end

   // cut a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         $display("unexpected run length: expected end seen timeout");
         summarize;
      end
   end

   initial begin
      logic e;
      logic [31:0] f;
      void'($urandom(37));
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(`VFBP_CTRL_ADDR, 32'h0000_0000, "ctrl reset");
      rd(`VFBP_FIELD_ADDR, 32'h0000_0000, "field reset");
      rd(`VFBP_STAT_ADDR, 32'h0000_0000, "stat reset");
      rd(`VFBP_COUNT_ADDR, 32'h0000_0000, "count reset");
      apb(1'b1, `VFBP_FIELD_ADDR, 32'hFFFF_FFFF, e);
      rd(`VFBP_FIELD_ADDR, `VFBP_FIELD_MASK, "field mask");
      apb(1'b0, 12'h010, 32'h0000_0000, e);
      chk("unmapped error", e, 32'h0000_0001);
      chk("unmapped data", q, 32'h0000_0000);
      $display("test registers done");
      f = $urandom & 32'h03FF_FFFF;
      frame(`VFBP_R72, `VFBP_PRED, 1'b0, f, 1'b1);
      frame(`VFBP_R28, `VFBP_PRED, 1'b0, f, 1'b1);
      frame(`VFBP_R80, `VFBP_PRED, 1'b0, f | 32'h0400_0000, 1'b1);
      rd(`VFBP_STAT_ADDR, 32'h0000_0608, "rate accumulator");
      $display("test variable rate done");
      for (int k = 0; k < 42; k++) begin
         f = $urandom & `VFBP_FIELD_MASK;
         if (k % 3 == 0)
            f[1:0] = `VFBP_BAND_WIDE;
         frame(3'(k / 3 % 7), 2'(k % 3), 1'($urandom), f, 1'b0);
      end
      rd(`VFBP_COUNT_ADDR, 32'd45, "frames done");
      apb(1'b0, `VFBP_STAT_ADDR, 32'h0000_0000, e);
      chk("last rate", q & 32'h0000_001F, 32'h0000_0018);
      $display("test frame layouts done");
      summarize;
   end
endmodule
